// File: cdc_cal_and_demod_config_regs.sv
// Functional notes
// RL1 - A 0-to-1 change of the trigger bit starts a synthesizer calibration.
// RL2 - Host writes the trigger bit back to 0 after calibration finishes.
// RL3 - Store-both bit saves result in banks A and B, else selected bank.
// RL4 - Wait is 14 ms at 2 MHz reference; short-wait bit halves it.
// RL5 - Calibration current bit doubles the current used during calibration.
// RL6 - Readable calibration-done bit, reset 0, set when calibration completes.
// RL7 - Three-bit DAC start value, reset 101; host should program 110.
// RL8 - Peak remover runs when enable bit is 1 (reset), bypassed at 0.
// RL9 - Seven-bit peak remover threshold, reset 0010110.
// RL10 - Each Manchester bit graded: 14 perfect, 0 constant level.
// RL11 - Violation flag when quality below limit N, reset 011; 000 never.
// RL12 - Filter mode 0 locks automatically; 1 follows manual lock bit.
// RL13 - Manual lock bit 0 free-runs the filter, 1 holds it locked.
// RL14 - Settling field: 11, 22, 43 or 86 baud periods, reset 11.
// RL15 - Active-low demodulator reset bit, reset 1, resets demodulator alone.
// RL16 - Lock select 1001 drives violation flag onto the lock pin.
// RL17 - Lock select 0101 drives calibration-done onto the lock pin.
// RL18 - Calibration-done clears when a new calibration is started.
// RL19 - Demodulator reset returns filter, peak state and violation flag to idle.
module cdc_cal_and_demod_config_regs
  import cdc_pkg::*;
#(
  parameter int CAL_WAIT_TICKS = CAL_WAIT_REF_TICKS,
  parameter int QUALITY_W = 4
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [6:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  output logic [7:0] o_reg_rdata,
  input wire logic i_bank_sel,
  input wire logic [3:0] i_lock_select,
  input wire logic i_ref_tick,
  input wire logic i_baud_tick,
  input wire logic i_rx_restart,
  input wire logic i_bit_valid,
  input wire logic [QUALITY_W-1:0] i_bit_quality,
  output logic o_cal_active,
  output logic o_cal_current_double,
  output logic [2:0] o_cal_dac_start,
  output logic o_cal_store_a,
  output logic o_cal_store_b,
  output logic o_peak_remover_enable,
  output logic [6:0] o_peak_threshold,
  output logic o_avg_filter_locked,
  output logic o_violation,
  output logic o_demod_reset,
  output logic o_lock_pin
);

  // ------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------
  localparam int WCNT_W = $clog2(CAL_WAIT_TICKS + 1);
  localparam logic [WCNT_W-1:0] WAIT_FULL = WCNT_W'(CAL_WAIT_TICKS);
  localparam logic [WCNT_W-1:0] WAIT_HALF = WCNT_W'(CAL_WAIT_TICKS / 2);

  generate
    if (CAL_WAIT_TICKS < 2) begin : g_bad_wait
      $error("CAL_WAIT_TICKS must be at least 2");
    end
    if (QUALITY_W < 4) begin : g_bad_qw
      $error("QUALITY_W must hold the value 14");
    end
  endgenerate

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [6:0] settle_baud(input logic [1:0] code);
    case (code)
      2'h0: settle_baud = SETTLE_BAUD_00;
      2'h1: settle_baud = SETTLE_BAUD_01;
      2'h2: settle_baud = SETTLE_BAUD_10;
      default: settle_baud = SETTLE_BAUD_11;
    endcase
  endfunction : settle_baud

  logic wr_cal;
  logic wr_peak;
  logic wr_dec;
  assign wr_cal = i_reg_wr && (i_reg_addr == ADDR_CALIBRATION_CONTROL);
  assign wr_peak = i_reg_wr && (i_reg_addr == ADDR_DEMOD_PEAK_CONFIG);
  assign wr_dec = i_reg_wr && (i_reg_addr == ADDR_DEMOD_DECISION_CONFIG);

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  logic cal_start_q, cal_start_d;
  logic cal_dual_q, cal_dual_d;
  logic cal_short_q, cal_short_d;
  logic cal_cur_q, cal_cur_d;
  logic [2:0] cal_iter_q, cal_iter_d;
  logic peak_en_q, peak_en_d;
  logic [6:0] peak_thr_q, peak_thr_d;
  logic [2:0] vlim_q, vlim_d;
  logic avg_hold_q, avg_hold_d;
  logic avg_manual_q, avg_manual_d;
  logic [1:0] settle_q, settle_d;
  logic demod_rst_n_q, demod_rst_n_d;
  logic cal_trigger;

  always_comb begin
    cal_start_d = cal_start_q;
    cal_dual_d = cal_dual_q;
    cal_short_d = cal_short_q;
    cal_cur_d = cal_cur_q;
    cal_iter_d = cal_iter_q;
    peak_en_d = peak_en_q;
    peak_thr_d = peak_thr_q;
    vlim_d = vlim_q;
    avg_hold_d = avg_hold_q;
    avg_manual_d = avg_manual_q;
    settle_d = settle_q;
    demod_rst_n_d = demod_rst_n_q;
    if (wr_cal) begin
      // Done bit is status only; writes to it are dropped
      cal_start_d = i_reg_wdata[CAL_START_BIT];
      cal_dual_d = i_reg_wdata[CAL_DUAL_BIT];
      cal_short_d = i_reg_wdata[CAL_SHORT_WAIT_BIT];
      cal_cur_d = i_reg_wdata[CAL_CURRENT_BIT];
      cal_iter_d = i_reg_wdata[CAL_ITER_LSB +: 3]; // [RL7]
    end
    if (wr_peak) begin
      peak_en_d = i_reg_wdata[PEAK_EN_BIT];
      peak_thr_d = i_reg_wdata[PEAK_THR_LSB +: 7]; // [RL9]
    end
    if (wr_dec) begin
      vlim_d = i_reg_wdata[VLIM_LSB +: 3];
      avg_hold_d = i_reg_wdata[AVG_HOLD_BIT];
      avg_manual_d = i_reg_wdata[AVG_MANUAL_BIT];
      settle_d = i_reg_wdata[SETTLE_LSB +: 2];
      demod_rst_n_d = i_reg_wdata[DEMOD_RST_N_BIT];
    end
  end

  // Only a fresh 0-to-1 write starts; host must clear the bit between runs
  assign cal_trigger = wr_cal && i_reg_wdata[CAL_START_BIT] && !cal_start_q; // [RL1] [RL2]

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      cal_start_q <= 1'b0;
      cal_dual_q <= 1'b0;
      cal_short_q <= 1'b0;
      cal_cur_q <= 1'b0;
      cal_iter_q <= CAL_ITER_RESET; // [RL7]
      peak_en_q <= PEAK_EN_RESET;
      peak_thr_q <= PEAK_THR_RESET;
      vlim_q <= VLIM_RESET;
      avg_hold_q <= 1'b0;
      avg_manual_q <= 1'b0;
      settle_q <= SETTLE_RESET;
      demod_rst_n_q <= DEMOD_RST_N_RESET;
    end else begin
      cal_start_q <= cal_start_d;
      cal_dual_q <= cal_dual_d;
      cal_short_q <= cal_short_d;
      cal_cur_q <= cal_cur_d;
      cal_iter_q <= cal_iter_d;
      peak_en_q <= peak_en_d;
      peak_thr_q <= peak_thr_d;
      vlim_q <= vlim_d;
      avg_hold_q <= avg_hold_d;
      avg_manual_q <= avg_manual_d;
      settle_q <= settle_d;
      demod_rst_n_q <= demod_rst_n_d;
    end
  end

  // ------------------------------------------------------------
  // Calibration sequencer
  // ------------------------------------------------------------
  cdc_cal_state_t cal_st_q, cal_st_d;
  logic [WCNT_W-1:0] wait_q, wait_d;
  logic cal_done_q, cal_done_d;
  logic store_a_q, store_a_d;
  logic store_b_q, store_b_d;

  always_comb begin
    cal_st_d = cal_st_q;
    wait_d = wait_q;
    cal_done_d = cal_done_q;
    store_a_d = 1'b0;
    store_b_d = 1'b0;
    case (cal_st_q)
      CDC_CAL_IDLE: begin
        if (cal_trigger) begin
          cal_st_d = CDC_CAL_WAIT;
          cal_done_d = 1'b0; // [RL18]
          // Wait counted in reference ticks so it tracks the reference rate
          // Short-wait bit written along with the start must already count
          wait_d = cal_short_d ? WAIT_HALF : WAIT_FULL; // [RL4]
        end
      end
      CDC_CAL_WAIT: begin
        if (i_ref_tick) begin
          if (wait_q <= WCNT_W'(1)) begin
            cal_st_d = CDC_CAL_STORE;
          end else begin
            wait_d = wait_q - WCNT_W'(1); // [RL4]
          end
        end
      end
      CDC_CAL_STORE: begin
        store_a_d = cal_dual_q || !i_bank_sel; // [RL3]
        store_b_d = cal_dual_q || i_bank_sel; // [RL3]
        cal_done_d = 1'b1; // [RL6]
        cal_st_d = CDC_CAL_IDLE;
      end
      default: begin
        cal_st_d = CDC_CAL_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      cal_st_q <= CDC_CAL_IDLE;
      wait_q <= '0;
      cal_done_q <= 1'b0; // [RL6]
      store_a_q <= 1'b0;
      store_b_q <= 1'b0;
    end else begin
      cal_st_q <= cal_st_d;
      wait_q <= wait_d;
      cal_done_q <= cal_done_d;
      store_a_q <= store_a_d;
      store_b_q <= store_b_d;
    end
  end

  // ------------------------------------------------------------
  // Demodulator control
  // ------------------------------------------------------------
  logic [6:0] settle_cnt_q, settle_cnt_d;
  logic auto_lock_q, auto_lock_d;
  logic viol_q, viol_d;
  logic [QUALITY_W-1:0] qual;

  always_comb begin
    settle_cnt_d = settle_cnt_q;
    auto_lock_d = auto_lock_q;
    viol_d = viol_q;
    // Grades above perfect are treated as perfect
    qual = (i_bit_quality > QUALITY_W'(QUALITY_PERFECT)) ? QUALITY_W'(QUALITY_PERFECT) : i_bit_quality; // [RL10]
    if (!demod_rst_n_q || i_rx_restart) begin
      settle_cnt_d = '0; // [RL15] [RL19]
      auto_lock_d = 1'b0; // [RL19]
      viol_d = 1'b0; // [RL19]
    end else begin
      if (i_baud_tick && !auto_lock_q) begin
        if (settle_cnt_q + 7'h01 >= settle_baud(settle_q)) begin
          auto_lock_d = 1'b1; // [RL14]
        end else begin
          settle_cnt_d = settle_cnt_q + 7'h01; // [RL14]
        end
      end
      if (i_bit_valid) begin
        // Flag follows the last graded bit
        viol_d = (vlim_q != 3'h0) && (qual < QUALITY_W'(vlim_q)); // [RL11]
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      settle_cnt_q <= '0;
      auto_lock_q <= 1'b0;
      viol_q <= 1'b0;
    end else begin
      settle_cnt_q <= settle_cnt_d;
      auto_lock_q <= auto_lock_d;
      viol_q <= viol_d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign o_cal_active = (cal_st_q != CDC_CAL_IDLE);
  assign o_cal_current_double = cal_cur_q && o_cal_active; // [RL5]
  assign o_cal_dac_start = cal_iter_q; // [RL7]
  assign o_cal_store_a = store_a_q;
  assign o_cal_store_b = store_b_q;
  // Peak remover is also held off while the demodulator sits in reset
  assign o_peak_remover_enable = peak_en_q && demod_rst_n_q; // [RL8] [RL19]
  assign o_peak_threshold = peak_thr_q; // [RL9]
  assign o_avg_filter_locked = demod_rst_n_q && (avg_manual_q ? avg_hold_q : auto_lock_q); // [RL12] [RL13]
  assign o_violation = viol_q;
  assign o_demod_reset = !demod_rst_n_q; // [RL15]

  always_comb begin
    case (i_lock_select)
      LOCK_SEL_VIOLATION: o_lock_pin = viol_q; // [RL16]
      LOCK_SEL_CAL_DONE: o_lock_pin = cal_done_q; // [RL17]
      default: o_lock_pin = 1'b0;
    endcase
  end

  always_comb begin
    case (i_reg_addr)
      ADDR_CALIBRATION_CONTROL: o_reg_rdata = {cal_start_q, cal_dual_q, cal_short_q, cal_cur_q, cal_done_q, cal_iter_q};
      ADDR_DEMOD_PEAK_CONFIG: o_reg_rdata = {peak_en_q, peak_thr_q};
      ADDR_DEMOD_DECISION_CONFIG: o_reg_rdata = {vlim_q, avg_hold_q, avg_manual_q, settle_q, demod_rst_n_q};
      default: o_reg_rdata = 8'h00;
    endcase
  end

endmodule : cdc_cal_and_demod_config_regs

// File: cdc_pkg.sv
package cdc_pkg;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [6:0] ADDR_CALIBRATION_CONTROL = 7'h0e;
  localparam logic [6:0] ADDR_DEMOD_PEAK_CONFIG = 7'h0f;
  localparam logic [6:0] ADDR_DEMOD_DECISION_CONFIG = 7'h10;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int CAL_START_BIT = 7;
  localparam int CAL_DUAL_BIT = 6;
  localparam int CAL_SHORT_WAIT_BIT = 5;
  localparam int CAL_CURRENT_BIT = 4;
  localparam int CAL_DONE_BIT = 3;
  localparam int CAL_ITER_LSB = 0;
  localparam int PEAK_EN_BIT = 7;
  localparam int PEAK_THR_LSB = 0;
  localparam int VLIM_LSB = 5;
  localparam int AVG_HOLD_BIT = 4;
  localparam int AVG_MANUAL_BIT = 3;
  localparam int SETTLE_LSB = 1;
  localparam int DEMOD_RST_N_BIT = 0;

  // ------------------------------------------------------------
  // Reset values and the normal DAC start value
  // ------------------------------------------------------------
  localparam logic [2:0] CAL_ITER_RESET = 3'h5;
  localparam logic [2:0] CAL_ITER_NORMAL = 3'h6;
  localparam logic PEAK_EN_RESET = 1'b1;
  localparam logic [6:0] PEAK_THR_RESET = 7'h16;
  localparam logic [2:0] VLIM_RESET = 3'h3;
  localparam logic [1:0] SETTLE_RESET = 2'h3;
  localparam logic DEMOD_RST_N_RESET = 1'b1;

  // ------------------------------------------------------------
  // Quality grading and lock pin codes
  // ------------------------------------------------------------
  localparam logic [3:0] QUALITY_PERFECT = 4'he;
  localparam logic [3:0] LOCK_SEL_CAL_DONE = 4'h5;
  localparam logic [3:0] LOCK_SEL_VIOLATION = 4'h9;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CAL_WAIT_US = 14000;
  localparam int CAL_REF_KHZ = 2000;
  localparam int CAL_WAIT_REF_TICKS = CAL_WAIT_US * CAL_REF_KHZ / 1000;
  localparam logic [6:0] SETTLE_BAUD_00 = 7'h0b;
  localparam logic [6:0] SETTLE_BAUD_01 = 7'h16;
  localparam logic [6:0] SETTLE_BAUD_10 = 7'h2b;
  localparam logic [6:0] SETTLE_BAUD_11 = 7'h56;

  typedef enum logic [2:0] {
    CDC_CAL_IDLE = 3'b001,
    CDC_CAL_WAIT = 3'b010,
    CDC_CAL_STORE = 3'b100
  } cdc_cal_state_t;

endpackage : cdc_pkg

// File: cdc_regs_asserts.sv
module cdc_regs_asserts
  import cdc_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [6:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic [7:0] o_reg_rdata,
  input wire logic i_bank_sel,
  input wire logic [3:0] i_lock_select,
  input wire logic i_bit_valid,
  input wire logic o_cal_active,
  input wire logic o_cal_store_a,
  input wire logic o_cal_store_b,
  input wire logic o_peak_remover_enable,
  input wire logic o_avg_filter_locked,
  input wire logic o_violation,
  input wire logic o_demod_reset,
  input wire logic o_lock_pin
);
  // Read data only tells us field values while the address points there
  wire cal_sel = i_reg_addr == ADDR_CALIBRATION_CONTROL;
  wire dec_sel = i_reg_addr == ADDR_DEMOD_DECISION_CONFIG;
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  property p_start; i_reg_wr && cal_sel && i_reg_wdata[7] && !o_reg_rdata[7] && !o_cal_active |=> o_cal_active; endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_bank; o_cal_store_a != o_cal_store_b |-> o_cal_store_b == $past(i_bank_sel); endproperty
  a_bank: assert property (p_bank) else $error("wrong bank");
  property p_end; $fell(o_cal_active) |-> o_cal_store_a || o_cal_store_b; endproperty
  a_end: assert property (p_end) else $error("no store");
  property p_done; o_cal_active && cal_sel |-> !o_reg_rdata[CAL_DONE_BIT]; endproperty
  a_done: assert property (p_done) else $error("stale done");
  property p_vzero; i_bit_valid && dec_sel && o_reg_rdata[7:5] == 3'h0 |=> !o_violation; endproperty
  a_vzero: assert property (p_vzero) else $error("flag at limit 0");
  property p_lk9; i_lock_select == LOCK_SEL_VIOLATION |-> o_lock_pin == o_violation; endproperty
  a_lk9: assert property (p_lk9) else $error("pin not flag");
  property p_lk5; i_lock_select == LOCK_SEL_CAL_DONE && cal_sel |-> o_lock_pin == o_reg_rdata[CAL_DONE_BIT]; endproperty
  a_lk5: assert property (p_lk5) else $error("pin not done");
  property p_mrst; o_demod_reset [*2] |-> !o_violation && !o_avg_filter_locked && !o_peak_remover_enable; endproperty
  a_mrst: assert property (p_mrst) else $error("demod not idle");
endmodule : cdc_regs_asserts

bind cdc_cal_and_demod_config_regs cdc_regs_asserts u_chk (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
  .i_reg_wr(i_reg_wr), .o_reg_rdata(o_reg_rdata), .i_bank_sel(i_bank_sel), .i_lock_select(i_lock_select),
  .i_bit_valid(i_bit_valid), .o_cal_active(o_cal_active), .o_cal_store_a(o_cal_store_a),
  .o_cal_store_b(o_cal_store_b), .o_peak_remover_enable(o_peak_remover_enable),
  .o_avg_filter_locked(o_avg_filter_locked), .o_violation(o_violation), .o_demod_reset(o_demod_reset),
  .o_lock_pin(o_lock_pin)
);

// File: cdc_host_model.sv
module cdc_host_model (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output logic [6:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_wr
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_addr = 7'h00;
    o_wdata = 8'h00;
    o_wr = 1'b0;
  end
  // Data goes stale after the strobe so a late sample shows up
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge i_clk);
    #1 o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(posedge i_clk);
    #1 o_wr = 1'b0;
    o_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge i_clk);
    #1 o_addr = a;
    #10 d = i_rdata;
  endtask : rd
endmodule : cdc_host_model

// File: tb_cal_and_demod_config_regs.sv
module tb_cal_and_demod_config_regs
  import cdc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk;
  logic rst = 1'b1;
  logic bank = 1'b0;
  logic rtk = 1'b0;
  logic btk = 1'b0;
  logic rrs = 1'b0;
  logic bv = 1'b0;
  logic [3:0] lsel = 4'h0;
  logic [3:0] q = 4'h0;
  logic [6:0] addr, thr;
  logic [7:0] wd, rdat, r;
  logic [2:0] dac;
  logic wr, act, cur, sa, sb, pen, lck, vio, drs, lp;
  int miscompares = 0;
  int checks_done = 0;

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  cdc_host_model u_host (.i_clk(clk), .i_rdata(rdat), .o_addr(addr), .o_wdata(wd), .o_wr(wr));
  // Short wait count keeps the calibration runs brief
  cdc_cal_and_demod_config_regs #(.CAL_WAIT_TICKS(8)) u_dut (
    .i_clk_sys(clk), .i_rst(rst), .i_reg_addr(addr), .i_reg_wdata(wd), .i_reg_wr(wr),
    .o_reg_rdata(rdat), .i_bank_sel(bank), .i_lock_select(lsel), .i_ref_tick(rtk),
    .i_baud_tick(btk), .i_rx_restart(rrs), .i_bit_valid(bv), .i_bit_quality(q),
    .o_cal_active(act), .o_cal_current_double(cur), .o_cal_dac_start(dac), .o_cal_store_a(sa),
    .o_cal_store_b(sb), .o_peak_remover_enable(pen), .o_peak_threshold(thr),
    .o_avg_filter_locked(lck), .o_violation(vio), .o_demod_reset(drs), .o_lock_pin(lp)
  );

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic tk(input bit b, input int n);
    repeat (n) begin
      @(posedge clk);
      #1 rtk = !b;
      btk = b;
      @(posedge clk);
      #1 rtk = 1'b0;
      btk = 1'b0;
    end
  endtask : tk
  task automatic bit_in(input logic [3:0] v);
    @(posedge clk);
    #1 bv = 1'b1;
    q = v;
    @(posedge clk);
    #1 bv = 1'b0;
  endtask : bit_in

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_rst;
    logic [6:0] a[4] = '{7'h0e, 7'h0f, 7'h10, 7'h11};
    logic [7:0] e[4] = '{8'h05, 8'h96, 8'h67, 8'h00};
    u_host.wr(7'h11, 8'hff);
    for (int i = 0; i < 4; i++) begin
      u_host.rd(a[i], r);
      chk(r, e[i]);
    end
    u_host.wr(ADDR_CALIBRATION_CONTROL, 8'h0e);
    u_host.rd(ADDR_CALIBRATION_CONTROL, r);
    chk(r, 8'h06);
    u_host.wr(ADDR_DEMOD_PEAK_CONFIG, 8'h2a);
    chk({pen, thr}, 8'h2a);
    u_host.wr(ADDR_DEMOD_PEAK_CONFIG, 8'h96);
    chk({pen, thr}, 8'h96);
  endtask : t_rst
  task automatic t_cal(input logic dual, input logic sw, input logic cu, input logic bk);
    logic [7:0] v;
    v = {1'b1, dual, sw, cu, 1'b0, CAL_ITER_NORMAL};
    bank = bk;
    lsel = LOCK_SEL_CAL_DONE;
    u_host.wr(ADDR_CALIBRATION_CONTROL, v);
    chk({act, cur, dac, rdat[3]}, {1'b1, cu, CAL_ITER_NORMAL, 1'b0});
    tk(1'b0, sw ? 3 : 7);
    chk({act, sa, sb}, 3'h4);
    tk(1'b0, 1);
    @(posedge clk);
    #1 chk({act, sa, sb, rdat[3], lp}, {1'b0, dual | !bk, dual | bk, 2'h3});
    u_host.wr(ADDR_CALIBRATION_CONTROL, {1'b0, v[6:0]});
  endtask : t_cal
  task automatic t_viol;
    int qv;
    lsel = LOCK_SEL_VIOLATION;
    for (int l = 0; l < 8; l++) begin
      u_host.wr(ADDR_DEMOD_DECISION_CONFIG, {l[2:0], 5'h07});
      for (int k = 0; k < 2; k++) begin
        qv = (k == 1) ? l : ((l == 0) ? 14 : l - 1);
        bit_in(qv[3:0]);
        chk({vio, lp}, {2{l != 0 && qv < l}});
      end
    end
    bit_in(4'h0);
    u_host.wr(ADDR_DEMOD_DECISION_CONFIG, 8'h66);
    bit_in(4'h0);
    chk({drs, vio, lck, pen}, 4'h8);
  endtask : t_viol
  task automatic t_avg;
    int s[4] = '{11, 22, 43, 86};
    for (int c = 0; c < 4; c++) begin
      u_host.wr(ADDR_DEMOD_DECISION_CONFIG, {5'h0c, c[1:0], 1'b1});
      @(posedge clk);
      #1 rrs = 1'b1;
      @(posedge clk);
      #1 rrs = 1'b0;
      tk(1'b1, s[c] - 1);
      chk(lck, 1'b0);
      tk(1'b1, 1);
      chk(lck, 1'b1);
    end
    u_host.wr(ADDR_DEMOD_DECISION_CONFIG, 8'h6f);
    chk(lck, 1'b0);
    u_host.wr(ADDR_DEMOD_DECISION_CONFIG, 8'h7f);
    chk(lck, 1'b1);
  endtask : t_avg

  task automatic wrap_up;
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    t_rst;
    t_cal(1'b0, 1'b0, 1'b0, 1'b0);
    t_cal(1'b1, 1'b1, 1'b1, 1'b0);
    t_cal(1'b0, 1'b1, 1'b0, 1'b1);
    t_viol;
    t_avg;
    wrap_up;
  end
  // Whole run is a few hundred cycles
  initial begin
    #400000;
    miscompares++;
    wrap_up;
  end
endmodule : tb_cal_and_demod_config_regs
